//--- rtl/rcs_pkg.sv
// Shared constants and types of the reset-cause recorder
package rcs_pkg;

	// Bit positions in the reset-cause status byte
	localparam int unsigned RCS_BIT_POR     = 7;
	localparam int unsigned RCS_BIT_PIN     = 6;
	localparam int unsigned RCS_BIT_WDOG    = 5;
	localparam int unsigned RCS_BIT_ILLEGAL_OPCODE_FLAG    = 4;
	localparam int unsigned RCS_BIT_ILLEGAL_ADDRESS_FLAG    = 3;
	localparam int unsigned RCS_BIT_CLKGEN  = 2;
	localparam int unsigned RCS_BIT_LOWV    = 1;
	localparam int unsigned RCS_BIT_UNUSED  = 0;

	// Status value after power-on: power-on and low-voltage flags
	localparam logic [7:0]  RCS_POR_VALUE   = 8'h82;
	localparam logic [7:0]  RCS_ZERO_BYTE   = 8'h00;

	// Force bit position in the debug forced-reset byte
	localparam int unsigned RCS_BIT_FORCE   = 0;

	// Register addresses in the CPU map
	localparam logic [15:0] RCS_ADDR_STATUS = 16'h1800;
	localparam logic [15:0] RCS_ADDR_DBGRST = 16'h1801;

	// Unpopulated gaps of the memory map
	localparam logic [15:0] RCS_GAP1_LO     = 16'h0470;
	localparam logic [15:0] RCS_GAP1_HI     = 16'h17FF;
	localparam logic [15:0] RCS_GAP2_LO     = 16'h1860;
	localparam logic [15:0] RCS_GAP2_HI     = 16'hBFFF;

	// Default length of the reset pulse issued to the system
	localparam int unsigned RCS_HOLD_DEFAULT = 8;

	typedef enum logic [1:0] {
		RCS_ST_RUN  = 2'b01,
		RCS_ST_HOLD = 2'b10
	} rcs_state_t;

endpackage : rcs_pkg

//--- rtl/rcs_addr_check.sv
// Illegal-address decoder for CPU accesses
`timescale 1ns/100ps
module rcs_addr_check
	import rcs_pkg::*;
(
	input  wire logic [15:0] addr_i,
	input  wire logic        access_i,
	output logic             illegal_o
);

	logic in_gap1;
	logic in_gap2;

	assign in_gap1 = (addr_i >= RCS_GAP1_LO) && (addr_i <= RCS_GAP1_HI);
	assign in_gap2 = (addr_i >= RCS_GAP2_LO) && (addr_i <= RCS_GAP2_HI);

	// Register regions never flagged
	// Reserved holes inside register pages fall outside both gaps by construction.
	assign illegal_o = access_i && (in_gap1 || in_gap2);

endmodule : rcs_addr_check

//--- rtl/rcs_reset_cause.sv
// Reset-cause recorder with debug-forced reset
//
// What this block does
// - Seven read-only cause flags, reads harmless
// - Debug-forced reset leaves all flags clear
// - Status write restarts watchdog, flags kept
// - Power-on sets bit 7 and bit 1
// - Low-voltage reset keeps bit 7, sets 1
// - Low-voltage reset needs both enables plus trip
// - Bit 6 for low external reset pin
// - Bit 5 watchdog, blocked when disabled
// - Bit 4 illegal opcode, stop/background included
// - Bit 3 illegal address access resets
// - Memory-to-high-page gap is illegal
// - High-page-to-flash gap is illegal
// - Register-region holes are not illegal
// - Bit 2 for clock-generator reset request
// - Active sources set, inactive ones clear
// - Force byte ignores user writes, reads zero
// - Debug write of 1 forces reset
`timescale 1ns/100ps
module rcs_reset_cause
	import rcs_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = RCS_HOLD_DEFAULT
)
(
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	// CPU access port
	input  wire logic [15:0] cpu_addr_i,
	input  wire logic        cpu_rd_i,
	input  wire logic        cpu_wr_i,
	input  wire logic [7:0]  cpu_wdata_i,
	output logic      [7:0]  cpu_rdata_o,
	// Serial background memory-write command, already decoded
	input  wire logic [15:0] dbg_addr_i,
	input  wire logic        dbg_wr_i,
	input  wire logic [7:0]  dbg_wdata_i,
	// Reset sources
	input  wire logic        reset_pin_n_i,
	input  wire logic        watchdog_timeout_i,
	input  wire logic        watchdog_enable_i,
	input  wire logic        opcode_unimpl_i,
	input  wire logic        stop_exec_i,
	input  wire logic        stop_enable_i,
	input  wire logic        background_instruction_exec_i,
	input  wire logic        background_enable_i,
	input  wire logic        clock_gen_reset_i,
	input  wire logic        low_voltage_trip_i,
	input  wire logic        low_voltage_reset_enable_i,
	input  wire logic        low_voltage_sense_enable_i,
	// To the system
	output logic             mcu_reset_o,
	output logic             watchdog_restart_o,
	output logic      [7:0]  reset_cause_status_o
);

	localparam int unsigned HOLD_W = (HOLD_CYCLES > 1) ? $clog2(HOLD_CYCLES + 1) : 1;
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);
	localparam logic [HOLD_W-1:0] HOLD_ZERO = '0;

	// Positions of all seven flags; two equal positions collapse into one bit
	localparam logic [7:0] FLAG_MASK = (8'h01 << RCS_BIT_POR) | (8'h01 << RCS_BIT_PIN)
		| (8'h01 << RCS_BIT_WDOG) | (8'h01 << RCS_BIT_ILLEGAL_OPCODE_FLAG) | (8'h01 << RCS_BIT_ILLEGAL_ADDRESS_FLAG)
		| (8'h01 << RCS_BIT_CLKGEN) | (8'h01 << RCS_BIT_LOWV);
	localparam logic [7:0] ZERO_MASK = 8'h01 << RCS_BIT_UNUSED;
	localparam logic [7:0] COLD_MASK = (8'h01 << RCS_BIT_POR) | (8'h01 << RCS_BIT_LOWV);
	localparam bit         STATUS_IN_GAP =
		((RCS_ADDR_STATUS >= RCS_GAP1_LO) && (RCS_ADDR_STATUS <= RCS_GAP1_HI))
		|| ((RCS_ADDR_STATUS >= RCS_GAP2_LO) && (RCS_ADDR_STATUS <= RCS_GAP2_HI));
	localparam bit         FORCE_IN_GAP =
		((RCS_ADDR_DBGRST >= RCS_GAP1_LO) && (RCS_ADDR_DBGRST <= RCS_GAP1_HI))
		|| ((RCS_ADDR_DBGRST >= RCS_GAP2_LO) && (RCS_ADDR_DBGRST <= RCS_GAP2_HI));

	if (HOLD_CYCLES < 1) begin : g_bad_hold
		$error("HOLD_CYCLES must be at least one");
	end

	// Seven distinct flag positions, none on the always-zero bit
	if ((FLAG_MASK & ZERO_MASK) != RCS_ZERO_BYTE) begin : g_bad_zero_bit
		$error("a cause flag sits on the always-zero bit");
	end
	if ((FLAG_MASK | ZERO_MASK) != 8'hFF) begin : g_bad_flag_bits
		$error("cause flag positions collide or leave the byte");
	end

	// The cold-start value must name exactly the power-on and low-voltage flags
	if (RCS_POR_VALUE != COLD_MASK) begin : g_bad_por_value
		$error("power-on status value does not match the flag positions");
	end

	// The force bit must lie inside its byte
	if ((8'h01 << RCS_BIT_FORCE) == RCS_ZERO_BYTE) begin : g_bad_force_bit
		$error("force bit position leaves the byte");
	end

	// Gaps must be ordered ranges, or the decoder silently flags nothing
	if (RCS_GAP1_LO > RCS_GAP1_HI) begin : g_bad_gap1
		$error("first illegal gap is empty");
	end
	if (RCS_GAP2_LO > RCS_GAP2_HI) begin : g_bad_gap2
		$error("second illegal gap is empty");
	end
	if (RCS_GAP1_HI >= RCS_GAP2_LO) begin : g_bad_gap_order
		$error("illegal gaps overlap or are out of order");
	end

	// A register inside a gap would reset the part on every access to it
	if (STATUS_IN_GAP) begin : g_bad_status_addr
		$error("status register lies in an illegal gap");
	end
	if (FORCE_IN_GAP) begin : g_bad_force_addr
		$error("force byte lies in an illegal gap");
	end
	if (RCS_ADDR_STATUS == RCS_ADDR_DBGRST) begin : g_bad_addr_pair
		$error("status register and force byte share one address");
	end

	typedef struct packed {
		rcs_state_t      state;
		logic [HOLD_W-1:0] hold_cnt;
		logic [7:0]      cause;
		logic [7:0]      rdata;
		logic            wd_restart;
	} rcs_regs_t;

	rcs_regs_t regs_reg;
	rcs_regs_t regs_next;

	logic       illegal_addr;
	logic       src_lowv;
	logic       src_wdog;
	logic       src_illegal_opcode_flag;
	logic       src_pin;
	logic       src_force;
	logic       any_src;
	logic [7:0] src_vec;
	logic       user_access;
	logic       status_hit;
	logic       status_wr;
	logic [7:0] cause_new;

	// Accesses are only meaningful while the system runs
	assign user_access = (regs_reg.state == RCS_ST_RUN) && (cpu_rd_i || cpu_wr_i);

	// Status write decode; only taken while the system runs
	assign status_hit = (cpu_addr_i == RCS_ADDR_STATUS);
	assign status_wr  = user_access && cpu_wr_i && status_hit;

	rcs_addr_check u_addr_check (
		.addr_i    (cpu_addr_i),
		.access_i  (user_access),
		.illegal_o (illegal_addr)
	);

	// Both enables and a trip needed
	assign src_lowv = low_voltage_trip_i && low_voltage_reset_enable_i
		&& low_voltage_sense_enable_i;

	assign src_wdog = watchdog_timeout_i && watchdog_enable_i;

	assign src_illegal_opcode_flag = opcode_unimpl_i || (stop_exec_i && !stop_enable_i)
		|| (background_instruction_exec_i && !background_enable_i);

	assign src_pin = !reset_pin_n_i;

	// Only the serial path reaches this
	assign src_force = dbg_wr_i && (dbg_addr_i == RCS_ADDR_DBGRST)
		&& dbg_wdata_i[RCS_BIT_FORCE];

	always_comb begin
		src_vec                 = RCS_ZERO_BYTE;
		src_vec[RCS_BIT_PIN]    = src_pin;
		src_vec[RCS_BIT_WDOG]   = src_wdog;
		src_vec[RCS_BIT_ILLEGAL_OPCODE_FLAG]   = src_illegal_opcode_flag;
		src_vec[RCS_BIT_ILLEGAL_ADDRESS_FLAG]   = illegal_addr;
		src_vec[RCS_BIT_CLKGEN] = clock_gen_reset_i;
		src_vec[RCS_BIT_LOWV]   = src_lowv;
	end

	assign any_src = (src_vec != RCS_ZERO_BYTE) || src_force;

	// One capture cell per status bit, used when a reset starts
	for (genvar b = 0; b < 8; b++) begin : g_cause
		if (b == RCS_BIT_POR) begin : g_por
			// Power-on flag kept on low voltage
			// Any other reset after power-up must not look like a cold start.
			assign cause_new[b] = src_lowv && regs_reg.cause[b];
		end else if (b == RCS_BIT_UNUSED) begin : g_zero
			assign cause_new[b] = 1'b0;
		end else begin : g_flag
			assign cause_new[b] = src_vec[b];
		end
	end

	always_comb begin
		regs_next            = regs_reg;
		regs_next.wd_restart = 1'b0;
		unique case (regs_reg.state)
			RCS_ST_RUN: begin
				if (any_src) begin
					regs_next.state    = RCS_ST_HOLD;
					regs_next.hold_cnt = HOLD_LAST;
					regs_next.cause    = cause_new;
					regs_next.rdata    = RCS_ZERO_BYTE;
				end else begin
					if (cpu_rd_i && (cpu_addr_i == RCS_ADDR_STATUS)) begin
						regs_next.rdata = regs_reg.cause;
					end else begin
						regs_next.rdata = RCS_ZERO_BYTE;
					end
					// User writes to force byte dropped
					// No term here reads cpu_wdata_i for that address.
				end
			end
			RCS_ST_HOLD: begin
				// Sources seen during the pulse are not recorded; a source
				// still active afterwards starts a fresh reset.
				regs_next.rdata = RCS_ZERO_BYTE;
				if (regs_reg.hold_cnt == HOLD_ZERO) begin
					regs_next.state = RCS_ST_RUN;
				end else begin
					regs_next.hold_cnt = regs_reg.hold_cnt - HOLD_W'(1);
				end
			end
		endcase
		// Any status write while the system runs restarts watchdog
		// Also when a reset starts in the same cycle; the written value is dropped.
		if (status_wr) begin
			regs_next.wd_restart = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			regs_reg.state      <= RCS_ST_RUN;
			regs_reg.hold_cnt   <= HOLD_ZERO;
			regs_reg.cause      <= RCS_POR_VALUE;
			regs_reg.rdata      <= RCS_ZERO_BYTE;
			regs_reg.wd_restart <= 1'b0;
		end else begin
			regs_reg <= regs_next;
		end
	end

	assign mcu_reset_o          = (regs_reg.state == RCS_ST_HOLD);
	assign watchdog_restart_o   = regs_reg.wd_restart;
	assign cpu_rdata_o          = regs_reg.rdata;
	assign reset_cause_status_o = regs_reg.cause;

	// Keeps the write data port referenced; its value never matters here.
	logic unused_wdata;
	assign unused_wdata = ^cpu_wdata_i;

endmodule : rcs_reset_cause

//--- test/rcs_reset_cause_assertions.sv
// Port checker of the reset-cause recorder
`timescale 1ns/100ps
module rcs_reset_cause_chk
	import rcs_pkg::*;
#(parameter int unsigned HOLD_CYCLES = RCS_HOLD_DEFAULT)
(
	input wire logic        mclk_i,
	input wire logic        srst_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic        cpu_rd_i,
	input wire logic        cpu_wr_i,
	input wire logic [7:0]  cpu_rdata_o,
	input wire logic [15:0] dbg_addr_i,
	input wire logic        dbg_wr_i,
	input wire logic [7:0]  dbg_wdata_i,
	input wire logic        reset_pin_n_i,
	input wire logic        mcu_reset_o,
	input wire logic        watchdog_restart_o,
	input wire logic [7:0]  reset_cause_status_o
);
	wire logic [7:0] st = reset_cause_status_o;
	int unsigned     cnt_reg;
	// Length of the running pulse
	always_ff @(posedge mclk_i) cnt_reg <= (srst_i || !mcu_reset_o) ? 0 : cnt_reg + 1;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	property p_zero; st[0] == 1'b0; endproperty
	a_zero: assert property (p_zero) else $error("status bit 0 set");
	property p_keep; !$rose(mcu_reset_o) && !$past(srst_i) |-> $stable(st); endproperty
	a_keep: assert property (p_keep) else $error("status moved");
	property p_por; $rose(mcu_reset_o) |-> st[7] == ($past(st[7]) && st[1]); endproperty
	a_por: assert property (p_por) else $error("power-on flag wrong");
	property p_pin; !reset_pin_n_i && !mcu_reset_o |=> mcu_reset_o && st[6]; endproperty
	a_pin: assert property (p_pin) else $error("pin reset lost");
	property p_wdr; cpu_wr_i && cpu_addr_i == RCS_ADDR_STATUS && !mcu_reset_o
		|=> watchdog_restart_o; endproperty
	a_wdr: assert property (p_wdr) else $error("no watchdog restart");
	property p_rd; cpu_rd_i && !mcu_reset_o && cpu_addr_i == RCS_ADDR_DBGRST
		|=> cpu_rdata_o == 8'h00; endproperty
	a_rd: assert property (p_rd) else $error("force byte read nonzero");
	property p_frc; dbg_wr_i && dbg_wdata_i[0] && dbg_addr_i == RCS_ADDR_DBGRST
		&& !mcu_reset_o |=> mcu_reset_o; endproperty
	a_frc: assert property (p_frc) else $error("forced reset lost");
	property p_hold; $fell(mcu_reset_o) && !$past(srst_i) |-> cnt_reg == HOLD_CYCLES; endproperty
	a_hold: assert property (p_hold) else $error("reset pulse length wrong");
	c_frc: cover property ($rose(mcu_reset_o) && st == 8'h00);
	c_lv: cover property ($rose(mcu_reset_o) && st[7]);
	c_wdr: cover property (watchdog_restart_o);
endmodule : rcs_reset_cause_chk
bind rcs_reset_cause rcs_reset_cause_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk_i (
	.mclk_i(mclk_i), .srst_i(srst_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i),
	.cpu_wr_i(cpu_wr_i), .cpu_rdata_o(cpu_rdata_o), .dbg_addr_i(dbg_addr_i),
	.dbg_wr_i(dbg_wr_i), .dbg_wdata_i(dbg_wdata_i), .reset_pin_n_i(reset_pin_n_i),
	.mcu_reset_o(mcu_reset_o), .watchdog_restart_o(watchdog_restart_o),
	.reset_cause_status_o(reset_cause_status_o));

//--- test/rcs_dbg_host.sv
// Debug host model issuing decoded background writes
`timescale 1ns/100ps
module rcs_dbg_host
	import rcs_pkg::*;
(
	output logic [15:0] dbg_addr_o = 16'h0000,
	output logic        dbg_wr_o = 1'b0,
	output logic [7:0]  dbg_wdata_o = 8'h00
);
	task put(input logic b);
		dbg_addr_o = RCS_ADDR_DBGRST;
		dbg_wdata_o = {dbg_wdata_o[6:0] ^ 7'h2b, b};
		dbg_wr_o = 1'b1;
	endtask : put
	// Idle lines flip so no stale value lingers
	task idle;
		dbg_wr_o = 1'b0;
		dbg_addr_o = ~dbg_addr_o;
		dbg_wdata_o = ~dbg_wdata_o;
	endtask : idle
endmodule : rcs_dbg_host

//--- test/rcs_reset_cause_tb.sv
// Self-checking bench of the reset-cause recorder
`timescale 1ns/100ps
module rcs_reset_cause_tb
	import rcs_pkg::*;
;
	localparam int unsigned HOLD = 2;
	localparam logic [15:0] TBL [8] = '{16'h0470, 16'h17FF, 16'h1860, 16'hBFFF,
		16'h046F, 16'hC000, 16'h1850, 16'h1800};
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wd = 8'h00;
	logic [11:0] src = 12'h000;
	logic [7:0]  rdata, st, exp_st;
	logic [15:0] daddr;
	logic [7:0]  ddata;
	logic        dwr, rst_o, wdr;
	int          seed, compares, miscompares;
	always #5 clk = ~clk;
	rcs_reset_cause #(.HOLD_CYCLES(HOLD)) rcs_reset_cause_i (.mclk_i(clk), .srst_i(srst),
		.cpu_addr_i(addr), .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_wdata_i(wd), .cpu_rdata_o(rdata),
		.dbg_addr_i(daddr), .dbg_wr_i(dwr), .dbg_wdata_i(ddata), .reset_pin_n_i(~src[0]),
		.watchdog_timeout_i(src[1]), .watchdog_enable_i(src[2]), .opcode_unimpl_i(src[3]),
		.stop_exec_i(src[4]), .stop_enable_i(src[5]), .background_instruction_exec_i(src[6]),
		.background_enable_i(src[7]), .clock_gen_reset_i(src[8]),
		.low_voltage_trip_i(src[9]), .low_voltage_reset_enable_i(src[10]),
		.low_voltage_sense_enable_i(src[11]), .mcu_reset_o(rst_o),
		.watchdog_restart_o(wdr), .reset_cause_status_o(st));
	rcs_dbg_host rcs_dbg_host_i (.dbg_addr_o(daddr), .dbg_wr_o(dwr), .dbg_wdata_o(ddata));
	function automatic logic [7:0] flags(input logic [11:0] s, input logic p,
		input logic [15:0] a);
		logic lv;
		logic il;
		lv = s[9] & s[10] & s[11];
		il = (a >= RCS_GAP1_LO && a <= RCS_GAP1_HI) || (a >= RCS_GAP2_LO && a <= RCS_GAP2_HI);
		return {p & lv, s[0], s[1] & s[2], s[3] | (s[4] & ~s[5]) | (s[6] & ~s[7]), il, s[8], lv, 1'b0};
	endfunction : flags
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic cpu(input logic r, input logic w, input logic [15:0] a);
		@(posedge clk);
		#1;
		rd = r;
		wr = w;
		addr = a;
		wd = 8'($random(seed)) | 8'h01;
		@(posedge clk);
		#1;
		rd = 1'b0;
		wr = 1'b0;
	endtask : cpu
	task automatic step(input logic [11:0] s, input logic [1:0] f, input logic r,
		input logic [15:0] a);
		logic [7:0] e;
		logic       act;
		@(posedge clk);
		#1;
		src = s;
		rd = r;
		addr = a;
		if (f[1]) rcs_dbg_host_i.put(f[0]);
		e = flags(s, exp_st[7], r ? a : 16'h1800);
		act = (|e) | (f == 2'b11);
		@(posedge clk);
		#1;
		src = 12'h000;
		rd = 1'b0;
		rcs_dbg_host_i.idle();
		cmp(8'(rst_o), 8'(act));
		if (act) exp_st = e;
		cmp(st, exp_st);
		repeat (HOLD) @(posedge clk);
	endtask : step
	task automatic conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		miscompares++;
		conclude();
	end
	initial begin
		seed = 32'h4f3f;
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		exp_st = RCS_POR_VALUE;
		cmp(st, exp_st);
		cpu(1'b1, 1'b0, RCS_ADDR_STATUS);
		cmp(rdata, exp_st);
		cpu(1'b1, 1'b0, RCS_ADDR_DBGRST);
		cmp(rdata, 8'h00);
		cpu(1'b0, 1'b1, RCS_ADDR_STATUS);
		cmp(8'(wdr), 8'h01);
		cmp(st, exp_st);
		cpu(1'b0, 1'b1, RCS_ADDR_DBGRST);
		cmp(8'(rst_o), 8'h00);
		step(12'he00, 2'b00, 1'b0, 16'h0000);
		step(12'h000, 2'b11, 1'b1, 16'h1850);
		for (int i = 0; i < 8; i++) step(12'h000, 2'b10, 1'b1, TBL[i]);
		repeat (300) step(12'($random(seed) & $random(seed)), 2'($random(seed)),
			1'($random(seed)), TBL[3'($random(seed))]);
		// Second reset in mid-run brings back the cold-start value
		@(posedge clk);
		#1;
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		exp_st = RCS_POR_VALUE;
		cmp(st, exp_st);
		cmp(8'(rst_o), 8'h00);
		cpu(1'b1, 1'b0, RCS_ADDR_STATUS);
		cmp(rdata, exp_st);
		conclude();
	end
endmodule : rcs_reset_cause_tb
